// ---- design/dsa_pkg.sv ----
// Purpose: shared constants and types of the accumulator adder
// Assumes: 16-bit register port, 40-bit accumulators
// Notes: register indices are word addresses on the plain port
package dsa_pkg;

  localparam int ACC_W = 40;
  localparam int PROD_W = 33;
  localparam int SHIFT_W = 6;
  localparam int REG_W = 16;
  localparam int ADDR_W = 3;
  localparam int EVT_W = 5;

  // register word addresses
  localparam logic [2:0] REG_CORE_CTRL = 3'h0;
  localparam logic [2:0] REG_INT_CTRL = 3'h1;
  localparam logic [2:0] REG_FLAGS = 3'h2;
  localparam logic [2:0] REG_EVT_STATUS = 3'h3;
  localparam logic [2:0] REG_EVT_MASK = 3'h4;

  // core_control_reg fields
  localparam int CTRL_CLIP_A_BIT = 7;
  localparam int CTRL_CLIP_B_BIT = 6;
  localparam int CTRL_STORE_BIT = 5;
  localparam int CTRL_WIDE_BIT = 4;
  localparam logic [7:0] CTRL_WR_MASK = 8'hF0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // interrupt_control_reg_one fields
  localparam int TRAP_A_BIT = 0;
  localparam int TRAP_B_BIT = 1;

  // flag register fields
  localparam int FLG_GUARD_A = 0;
  localparam int FLG_GUARD_B = 1;
  localparam int FLG_GUARD_ANY = 2;
  localparam int FLG_CLIP_A = 3;
  localparam int FLG_CLIP_B = 4;
  localparam int FLG_CLIP_ANY = 5;

  // event status and mask fields
  localparam int EVT_GUARD_A = 0;
  localparam int EVT_GUARD_B = 1;
  localparam int EVT_CLIP_A = 2;
  localparam int EVT_CLIP_B = 3;
  localparam int EVT_CATASTROPHIC = 4;
  localparam logic [4:0] EVT_RESET = 5'h00;

  // saturation limits
  localparam logic [39:0] SAT_MAX_NARROW = 40'h007FFFFFFF;
  localparam logic [39:0] SAT_MIN_NARROW = 40'hFF80000000;
  localparam logic [39:0] SAT_MAX_WIDE = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT_MIN_WIDE = 40'h8000000000;
  localparam logic [15:0] STORE_MAX = 16'h7FFF;
  localparam logic [15:0] STORE_MIN = 16'h8000;

  typedef enum logic [3:0] {
    DSA_OP_NOP,
    DSA_OP_ADD,
    DSA_OP_SUB,
    DSA_OP_LOAD,
    DSA_OP_CLEAR,
    DSA_OP_ACC_ADD,
    DSA_OP_ACC_SUB,
    DSA_OP_NEG,
    DSA_OP_STORE
  } dsa_op_type;

  typedef struct packed {
    logic valid;
    dsa_op_type code;
    logic dest_b;
    logic use_product;
    logic [32:0] product;
    logic [39:0] data;
    logic use_shift;
    logic signed [5:0] shift;
    logic carry_in;
  } dsa_req_type;

  typedef struct packed {
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic guard_a;
    logic guard_b;
    logic clip_a;
    logic clip_b;
    logic [7:0] core_ctrl;
    logic [1:0] trap_en;
    logic [4:0] evt;
    logic [4:0] mask;
    logic [15:0] rdata;
    logic [15:0] store_data;
    logic store_valid;
  } dsa_state_type;

endpackage

// ---- design/dsa_shifter.sv ----
// Purpose: arithmetic barrel shifter for operand prescale
// Assumes: positive amount shifts right, negative shifts left
// Notes: purely combinational
`timescale 1ns/100ps
module dsa_shifter #(
  parameter int ACC_W = 40,
  parameter int SHIFT_W = 6
) (
  // operand
  input wire logic [ACC_W-1:0] data_in,
  input wire logic signed [SHIFT_W-1:0] amount,
  // result
  output logic [ACC_W-1:0] data_out
);

  if (SHIFT_W < 2 || (1 << (SHIFT_W - 1)) > ACC_W)
  begin : g_check
    $error("dsa_shifter: shift width does not fit the operand");
  end

  logic [SHIFT_W-1:0] mag;

  always_comb
  begin
    mag = '0;
    data_out = data_in;
    if (amount < 0)
    begin
      mag = SHIFT_W'(-amount);
      data_out = data_in << mag;
    end
    else
    begin
      mag = SHIFT_W'(amount);
      data_out = ACC_W'($signed(data_in) >>> mag);
    end
  end

endmodule

// ---- design/dsa_accumulator.sv ----
// Purpose: 40-bit dual accumulator adder/subtracter with saturation
// Assumes: one operation per cycle, registers on a plain strobe port
// Notes: flags and accumulators update on the edge after a request
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module dsa_accumulator (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operation request
  input wire dsa_pkg::dsa_req_type req,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // accumulators
  output logic [39:0] acc_a,
  output logic [39:0] acc_b,
  // store path
  output logic [15:0] store_data,
  output logic store_valid,
  // status flags
  output logic guard_overflow_a,
  output logic guard_overflow_b,
  output logic guard_overflow_any,
  output logic clip_flag_a,
  output logic clip_flag_b,
  output logic clip_flag_any,
  // trap and interrupt
  output logic trap_req_a,
  output logic trap_req_b,
  output logic irq
);

  dsa_pkg::dsa_state_type st;
  dsa_pkg::dsa_state_type next_st;

  logic [39:0] src;
  logic [39:0] other;
  logic [39:0] ext;
  logic [39:0] shifted;
  logic [39:0] operand;
  logic [39:0] in_a;
  logic [39:0] in_b;
  logic [40:0] sum_w;
  logic [39:0] sum;
  logic cin, zero_a, compl_b, thru_adder;
  logic cat_ov, guard_ov, narrow_ov, sign_true;
  logic clip_en;
  logic wide;
  logic need_clip;
  logic [39:0] result;
  logic [15:0] store_val;
  logic [4:0] evt_set;
  logic [4:0] evt_clr;
  logic clip_clr_a, clip_clr_b;
  logic [15:0] flags_word;

  function automatic logic all_same(input logic [39:0] v, input int lo);
    logic same;
    same = 1'b1;
    for (int i = lo; i < 39; i++)
    begin
      if (v[i] != v[39])
      begin
        same = 1'b0;
      end
    end
    return same;
  endfunction

  dsa_shifter #(
    .ACC_W(dsa_pkg::ACC_W),
    .SHIFT_W(dsa_pkg::SHIFT_W)
  ) u_shifter (
    .data_in(ext),
    .amount(req.shift),
    .data_out(shifted)
  );

  // operand selection and adder
  always_comb
  begin
    src = req.dest_b ? st.acc_b : st.acc_a;
    other = req.dest_b ? st.acc_a : st.acc_b;
    ext = req.use_product ?
      {{(dsa_pkg::ACC_W - dsa_pkg::PROD_W){req.product[32]}},
       req.product} : req.data;
    operand = ext;
    zero_a = 1'b0;
    compl_b = 1'b0;
    cin = 1'b0;
    thru_adder = req.valid;
    case (req.code)
      dsa_pkg::DSA_OP_ADD:
      begin
        operand = req.use_shift ? shifted : ext;
        cin = req.carry_in;
      end
      dsa_pkg::DSA_OP_SUB:
      begin
        compl_b = 1'b1;
        cin = req.carry_in;
      end
      dsa_pkg::DSA_OP_LOAD:
      begin
        operand = req.use_shift ? shifted : ext;
        zero_a = 1'b1;
      end
      dsa_pkg::DSA_OP_CLEAR:
      begin
        operand = '0;
        zero_a = 1'b1;
      end
      dsa_pkg::DSA_OP_ACC_ADD:
      begin
        operand = other;
      end
      dsa_pkg::DSA_OP_ACC_SUB:
      begin
        operand = other;
        compl_b = 1'b1;
        cin = 1'b1;
      end
      dsa_pkg::DSA_OP_NEG:
      begin
        operand = src;
        zero_a = 1'b1;
        compl_b = 1'b1;
        cin = 1'b1;
      end
      default:
      begin
        thru_adder = 1'b0;
      end
    endcase
    in_a = zero_a ? '0 : src;
    in_b = compl_b ? ~operand : operand;
    sum_w = {1'b0, in_a} + {1'b0, in_b} + {40'h0000000000, cin};
    sum = sum_w[39:0];
  end

  // overflow detection and saturation
  always_comb
  begin
    cat_ov = (in_a[39] == in_b[39]) && (sum[39] != in_a[39]);
    guard_ov = ~all_same(sum, 32);
    narrow_ov = ~all_same(sum, 31);
    sign_true = cat_ov ? ~sum[39] : sum[39];
    clip_en = req.dest_b ? st.core_ctrl[dsa_pkg::CTRL_CLIP_B_BIT] :
      st.core_ctrl[dsa_pkg::CTRL_CLIP_A_BIT];
    wide = st.core_ctrl[dsa_pkg::CTRL_WIDE_BIT];
    need_clip = clip_en && (wide ? cat_ov : (cat_ov || narrow_ov));
    result = sum;
    if (need_clip)
    begin
      if (wide)
      begin
        result = sign_true ? dsa_pkg::SAT_MIN_WIDE :
          dsa_pkg::SAT_MAX_WIDE;
      end
      else
      begin
        result = sign_true ? dsa_pkg::SAT_MIN_NARROW :
          dsa_pkg::SAT_MAX_NARROW;
      end
    end
    store_val = src[31:16];
    if (st.core_ctrl[dsa_pkg::CTRL_STORE_BIT] && !all_same(src, 31))
    begin
      store_val = src[39] ? dsa_pkg::STORE_MIN :
        dsa_pkg::STORE_MAX;
    end
  end

  // register decode helpers
  always_comb
  begin
    evt_set = '0;
    evt_set[dsa_pkg::EVT_GUARD_A] = thru_adder & ~req.dest_b & guard_ov;
    evt_set[dsa_pkg::EVT_GUARD_B] = thru_adder & req.dest_b & guard_ov;
    evt_set[dsa_pkg::EVT_CLIP_A] = thru_adder & ~req.dest_b & need_clip;
    evt_set[dsa_pkg::EVT_CLIP_B] = thru_adder & req.dest_b & need_clip;
    evt_set[dsa_pkg::EVT_CATASTROPHIC] = thru_adder & cat_ov;
    evt_clr = '0;
    if (reg_wr && reg_addr == dsa_pkg::REG_EVT_STATUS)
    begin
      evt_clr = reg_wdata[4:0];
    end
    clip_clr_a = reg_wr && reg_addr == dsa_pkg::REG_FLAGS &&
      reg_wdata[dsa_pkg::FLG_CLIP_A];
    clip_clr_b = reg_wr && reg_addr == dsa_pkg::REG_FLAGS &&
      reg_wdata[dsa_pkg::FLG_CLIP_B];
    flags_word = '0;
    flags_word[dsa_pkg::FLG_GUARD_A] = st.guard_a;
    flags_word[dsa_pkg::FLG_GUARD_B] = st.guard_b;
    flags_word[dsa_pkg::FLG_GUARD_ANY] = st.guard_a | st.guard_b;
    flags_word[dsa_pkg::FLG_CLIP_A] = st.clip_a;
    flags_word[dsa_pkg::FLG_CLIP_B] = st.clip_b;
    flags_word[dsa_pkg::FLG_CLIP_ANY] = st.clip_a | st.clip_b;
  end

  // next state
  always_comb
  begin
    next_st = st;
    next_st.store_valid = 1'b0;
    if (thru_adder)
    begin
      if (req.dest_b)
      begin
        next_st.acc_b = result;
        next_st.guard_b = guard_ov;
      end
      else
      begin
        next_st.acc_a = result;
        next_st.guard_a = guard_ov;
      end
    end
    if (req.valid && req.code == dsa_pkg::DSA_OP_STORE)
    begin
      next_st.store_data = store_val;
      next_st.store_valid = 1'b1;
    end
    // clip flags sticky, set wins over clear
    next_st.clip_a = (st.clip_a & ~clip_clr_a) |
      evt_set[dsa_pkg::EVT_CLIP_A];
    next_st.clip_b = (st.clip_b & ~clip_clr_b) |
      evt_set[dsa_pkg::EVT_CLIP_B];
    next_st.evt = (st.evt & ~evt_clr) | evt_set;
    if (reg_wr)
    begin
      case (reg_addr)
        dsa_pkg::REG_CORE_CTRL:
        begin
          next_st.core_ctrl = reg_wdata[7:0] & dsa_pkg::CTRL_WR_MASK;
        end
        dsa_pkg::REG_INT_CTRL:
        begin
          next_st.trap_en = reg_wdata[1:0];
        end
        dsa_pkg::REG_EVT_MASK:
        begin
          next_st.mask = reg_wdata[4:0];
        end
        default:
        begin
          next_st.mask = st.mask;
        end
      endcase
    end
    next_st.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        dsa_pkg::REG_CORE_CTRL:
        begin
          next_st.rdata = {8'h00, st.core_ctrl};
        end
        dsa_pkg::REG_INT_CTRL:
        begin
          next_st.rdata = {14'h0000, st.trap_en};
        end
        dsa_pkg::REG_FLAGS:
        begin
          next_st.rdata = flags_word;
        end
        dsa_pkg::REG_EVT_STATUS:
        begin
          next_st.rdata = {11'h000, st.evt};
        end
        dsa_pkg::REG_EVT_MASK:
        begin
          next_st.rdata = {11'h000, st.mask};
        end
        default:
        begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.core_ctrl <= dsa_pkg::CTRL_RESET;
      st.evt <= dsa_pkg::EVT_RESET;
      st.mask <= dsa_pkg::EVT_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign acc_a = st.acc_a;
  assign acc_b = st.acc_b;
  assign store_data = st.store_data;
  assign store_valid = st.store_valid;
  assign guard_overflow_a = st.guard_a;
  assign guard_overflow_b = st.guard_b;
  assign guard_overflow_any = st.guard_a | st.guard_b;
  assign clip_flag_a = st.clip_a;
  assign clip_flag_b = st.clip_b;
  assign clip_flag_any = st.clip_a | st.clip_b;
  assign trap_req_a = st.guard_a &
    st.trap_en[dsa_pkg::TRAP_A_BIT];
  assign trap_req_b = st.guard_b &
    st.trap_en[dsa_pkg::TRAP_B_BIT];
  assign irq = |(st.evt & st.mask);

endmodule

// ---- dv/dsa_core_model.sv ----
// Purpose: core-side request source for the accumulator adder
// Assumes: one request per issue call, one idle cycle after it
// Notes: an idle request carries inverted stale fields
`timescale 1ns/100ps
module dsa_core_model (
  // clock
  input wire logic clk,
  // request to the block
  output dsa_pkg::dsa_req_type req
);
  initial req = '0;
  task automatic issue(input dsa_pkg::dsa_req_type r);
    dsa_pkg::dsa_req_type rel;
    @(posedge clk);
    req <= r;
    @(posedge clk);
    rel = ~r;
    rel.valid = 1'b0;
    req <= rel;
  endtask
endmodule

// ---- dv/dsa_accumulator_chk.sv ----
// Purpose: port-level checks of the accumulator adder
// Assumes: single clock, synchronous active-low reset
// Notes: bound to every accumulator instance
`timescale 1ns/100ps
module dsa_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests and registers
  input wire dsa_pkg::dsa_req_type req,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // results
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  input wire logic store_valid,
  input wire logic guard_overflow_a,
  input wire logic guard_overflow_b,
  input wire logic guard_overflow_any,
  input wire logic clip_flag_a,
  input wire logic clip_flag_b,
  input wire logic clip_flag_any,
  input wire logic trap_req_a,
  input wire logic trap_req_b
);
  logic load_narrow;
  logic load_guard;
  always_comb
  begin
    load_narrow = &req.data[39:31] | ~|req.data[39:31];
    load_guard = !(&req.data[39:32] | ~|req.data[39:32]);
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence load_a;
    req.valid && req.code == dsa_pkg::DSA_OP_LOAD && !req.dest_b
      && !req.use_shift && !req.use_product;
  endsequence
  sequence op_a;
    req.valid && !req.dest_b;
  endsequence
  chk_guard_any_or:
    assert property (guard_overflow_any ==
      (guard_overflow_a | guard_overflow_b))
    else $error("guard any is not the or");
  chk_clip_any_or:
    assert property (clip_flag_any == (clip_flag_a | clip_flag_b))
    else $error("clip any is not the or");
  chk_trap_gate_a:
    assert property (trap_req_a |-> guard_overflow_a)
    else $error("trap a without guard a");
  chk_trap_gate_b:
    assert property (trap_req_b |-> guard_overflow_b)
    else $error("trap b without guard b");
  chk_load_value:
    assert property ((load_a ##0 load_narrow) |=> acc_a == $past(req.data))
    else $error("load value wrong");
  chk_load_guard:
    assert property (load_a |=> guard_overflow_a == $past(load_guard))
    else $error("guard flag after load wrong");
  chk_other_acc:
    assert property (op_a |=> $stable(acc_b) && $stable(guard_overflow_b))
    else $error("other accumulator disturbed");
  chk_idle_hold:
    assert property (!req.valid |=> $stable(acc_a) && $stable(acc_b)
      && $stable(guard_overflow_a))
    else $error("state changed without request");
  chk_clip_sticky:
    assert property (clip_flag_a && !(reg_wr && reg_wdata[3]
      && reg_addr == dsa_pkg::REG_FLAGS) |=> clip_flag_a)
    else $error("clip flag a lost");
  chk_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without read");
  chk_store_pulse:
    assert property (req.valid && req.code == dsa_pkg::DSA_OP_STORE
      |=> store_valid)
    else $error("store result missing");
endmodule
bind dsa_accumulator dsa_chk u_chk (.clk, .rst_n, .req, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_a, .acc_b, .store_valid,
  .guard_overflow_a, .guard_overflow_b, .guard_overflow_any, .clip_flag_a,
  .clip_flag_b, .clip_flag_any, .trap_req_a, .trap_req_b);

// ---- dv/dsa_accumulator_bench.sv ----
// Purpose: self-checking bench of the accumulator adder
// Assumes: core model issues operations, bench drives registers
// Notes: expected values worked by hand
`timescale 1ns/100ps
module dsa_accumulator_bench;
  logic clk, rst_n, reg_wr, reg_rd, store_valid, irq;
  logic guard_overflow_a, guard_overflow_b, guard_overflow_any;
  logic clip_flag_a, clip_flag_b, clip_flag_any, trap_req_a, trap_req_b;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, store_data;
  logic [39:0] acc_a, acc_b;
  dsa_pkg::dsa_req_type req;
  int n_fail, n_tests;
  dsa_core_model core (.clk, .req);
  dsa_accumulator dut (.clk, .rst_n, .req, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .acc_a, .acc_b, .store_data,
    .store_valid, .guard_overflow_a, .guard_overflow_b,
    .guard_overflow_any, .clip_flag_a, .clip_flag_b, .clip_flag_any,
    .trap_req_a, .trap_req_b, .irq);
  always #20 clk = ~clk;
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({39'h0, got}, {39'h0, exp});
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp({24'h0, reg_rdata}, {24'h0, e});
  endtask
  task automatic op(input dsa_pkg::dsa_op_type c, input logic b,
    input logic [39:0] d, input logic ci = 1'b0, input logic us = 1'b0,
    input logic signed [5:0] sh = 6'sh00, input logic up = 1'b0,
    input logic [32:0] pr = 33'h0);
    core.issue('{1'b1, c, b, up, pr, d, us, sh, ci});
    #1;
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(3'(i), 16'h0000);
    wr(3'h0, 16'hFFFF);
    rd(3'h0, 16'h00F0);
    wr(3'h0, 16'h0000);
    op(dsa_pkg::DSA_OP_ADD, 0, 40'h5, 1'b1);
    cmp(acc_a, 40'h6);
    op(dsa_pkg::DSA_OP_SUB, 0, 40'h2, 1'b1);
    cmp(acc_a, 40'h4);
    op(dsa_pkg::DSA_OP_SUB, 0, 40'h1, 1'b0);
    cmp(acc_a, 40'h2);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h100, 1'b0, 1'b1, 6'sh04);
    cmp(acc_a, 40'h10);
    op(dsa_pkg::DSA_OP_ADD, 0, 40'h3, 1'b0, 1'b1, 6'sh3F);
    cmp(acc_a, 40'h16);
    op(dsa_pkg::DSA_OP_LOAD, 1, 40'h0, 1'b0, 1'b0, 6'sh00, 1'b1,
      33'h100000000);
    cmp(acc_b, 40'hFF00000000);
    op(dsa_pkg::DSA_OP_NEG, 0, 40'h0);
    cmp(acc_a, 40'hFFFFFFFFEA);
    op(dsa_pkg::DSA_OP_CLEAR, 0, 40'h0);
    cmp(acc_a, 40'h0);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h0100000000);
    cmp_bit(guard_overflow_any, 1'b1);
    rd(dsa_pkg::REG_FLAGS, 16'h0005);
    wr(dsa_pkg::REG_INT_CTRL, 16'h0001);
    cmp_bit(trap_req_a, 1'b1);
    cmp_bit(trap_req_b, 1'b0);
    wr(dsa_pkg::REG_INT_CTRL, 16'h0000);
    cmp_bit(trap_req_a, 1'b0);
    wr(dsa_pkg::REG_EVT_MASK, 16'h0001);
    cmp_bit(irq, 1'b1);
    wr(dsa_pkg::REG_EVT_STATUS, 16'h0001);
    cmp_bit(irq, 1'b0);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h1);
    cmp_bit(guard_overflow_a, 1'b0);
    op(dsa_pkg::DSA_OP_LOAD, 1, 40'hFE00000000);
    cmp_bit(guard_overflow_b, 1'b1);
    cmp_bit(trap_req_b, 1'b0);
    wr(dsa_pkg::REG_INT_CTRL, 16'h0002);
    cmp_bit(trap_req_b, 1'b1);
    cmp_bit(trap_req_a, 1'b0);
    wr(dsa_pkg::REG_INT_CTRL, 16'h0000);
    op(dsa_pkg::DSA_OP_NOP, 1, 40'h0);
    cmp_bit(guard_overflow_b, 1'b1);
    wr(dsa_pkg::REG_CORE_CTRL, 16'h0080);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h0080000000);
    cmp(acc_a, dsa_pkg::SAT_MAX_NARROW);
    cmp_bit(clip_flag_any, 1'b1);
    op(dsa_pkg::DSA_OP_LOAD, 1, 40'h0080000000);
    cmp(acc_b, 40'h0080000000);
    cmp_bit(clip_flag_b, 1'b0);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'hFF7FFFFFFF);
    cmp(acc_a, dsa_pkg::SAT_MIN_NARROW);
    wr(dsa_pkg::REG_FLAGS, 16'h0008);
    cmp_bit(clip_flag_a, 1'b0);
    wr(dsa_pkg::REG_CORE_CTRL, 16'h0090);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h1);
    op(dsa_pkg::DSA_OP_ADD, 0, 40'h7FFFFFFFFF);
    cmp(acc_a, dsa_pkg::SAT_MAX_WIDE);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'hFFFFFFFFFE);
    op(dsa_pkg::DSA_OP_SUB, 0, 40'h7FFFFFFFFF, 1'b1);
    cmp(acc_a, dsa_pkg::SAT_MIN_WIDE);
    wr(dsa_pkg::REG_CORE_CTRL, 16'h0000);
    wr(dsa_pkg::REG_EVT_STATUS, 16'h001F);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h1);
    op(dsa_pkg::DSA_OP_ADD, 0, 40'h7FFFFFFFFF);
    cmp(acc_a, 40'h8000000000);
    rd(dsa_pkg::REG_EVT_STATUS, 16'h0011);
    wr(dsa_pkg::REG_CORE_CTRL, 16'h0020);
    op(dsa_pkg::DSA_OP_LOAD, 0, 40'h0080000000);
    op(dsa_pkg::DSA_OP_STORE, 0, 40'h0);
    cmp({24'h0, store_data}, {24'h0, dsa_pkg::STORE_MAX});
    cmp_bit(store_valid, 1'b1);
    op(dsa_pkg::DSA_OP_ACC_ADD, 1, 40'h0);
    cmp(acc_b, 40'h0100000000);
    cmp_bit(guard_overflow_b, 1'b1);
    cmp_bit(store_valid, 1'b0);
    op(dsa_pkg::DSA_OP_ACC_SUB, 0, 40'h0);
    cmp(acc_a, 40'hFF80000000);
    report_and_stop();
  end
endmodule
